// ### include/i2c_port_consts.svh
`ifndef I2C_PORT_CONSTS_SVH
`define I2C_PORT_CONSTS_SVH
// ===========================================================
// slave address
`define ADDR_FIXED_HI         5'h13
// ===========================================================
// strap codes (pin tied to gnd, supply, sda, scl)
`define STRAP_GND             2'h0
`define STRAP_VDD             2'h1
`define STRAP_SDA             2'h2
`define STRAP_SCL             2'h3
// ===========================================================
// pointer reset value
`define PTR_RESET             8'h00
// ===========================================================
// bus timeout: 31 ms, counted at 250 MHz
`define TIMEOUT_MS            31
`define CLK_MHZ               250
`define TIMEOUT_CYCLES        (`TIMEOUT_MS * 1000 * `CLK_MHZ)
`endif

// ### include/i2c_port_pkg.sv
package i2c_port_pkg;
   // link state, one-hot
   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_ADDR  = 6'b000010,
      ST_AACK  = 6'b000100,
      ST_RX    = 6'b001000,
      ST_TX    = 6'b010000,
      ST_MACK  = 6'b100000
   } link_state_type;
   // register access request toward the core
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_req_type;
endpackage

// ### verilog/sync2.sv
`timescale 1ns/10ps
// ===========================================================
// two-flop level synchroniser
module sync2 #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             srst_in,
   // data
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_q;
   // first flop feeds only the second
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         meta_q <= '0;
         q_out  <= '0;
      end else begin
         meta_q <= d_in;
         q_out  <= meta_q;
      end
   end
endmodule // sync2

// ### verilog/gpio_expander_i2c_slave_port.sv
// Functional notes
// - scl is input only; sda is input plus open-drain pull-low output
// - start, address with direction, pointer byte, data bytes, stop
// - start/stop are sda edges while scl high, detected anytime
// - idle bus rests with both lines released high
// - one bit per scl pulse; sda steady while scl high
// - ninth pulse carries acknowledge, receiver holds sda low
// - device acks received bytes; master acks bytes device sends
// - eighth bit after address: low write, high read
// - upper five address bits must be 1,0,0,1,1
// - low two address bits come from the strap pin wiring
// - first written byte is the pointer; stop after it changes nothing
// - data bytes go to pointer register, pointer advances each byte
// - reads start at stored pointer and advance after each byte
// - timeout: line low ~31 ms in transfer resets interface; here the reset waits for the next scl rise
// - timeout enabled when config bit d7 is clear
`timescale 1ns/10ps
`include "i2c_port_consts.svh"
module gpio_expander_i2c_slave_port #(
   parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
   // system clock and reset
   input  wire logic                      clk_in,
   input  wire logic                      srst_in,
   // link clock (scl as clock) and link pins
   input  wire logic                      scl_in,
   input  wire logic                      sda_in,
   output logic                           sda_out,
   output logic                           sda_oe_out,
   // address strap sense: pin seen low/high, shorted to sda, to scl
   input  wire logic                      strap_lo_in,
   input  wire logic                      strap_hi_in,
   input  wire logic                      strap_sda_in,
   // timeout disable (config bit d7)
   input  wire logic                      timeout_dis_in,
   // register core side
   output i2c_port_pkg::reg_req_type      req_out,
   input  wire logic [7:0]                rd_data_in,
   output logic [7:0]                     ptr_out,
   output logic                           busy_out
);
   // ========================================================
   // link domain: bit engine clocked by scl
   // link logic has no reset of its own: it powers up idle and is
   // brought back to idle by stop or the timeout toggle, and restarted into address by start
   i2c_port_pkg::link_state_type state_q = i2c_port_pkg::ST_IDLE;
   logic [2:0] bit_q       = 3'd0;
   logic [7:0] shift_q     = 8'h00;
   logic       ptr_phase_q = 1'b0;        // next rx byte is the pointer
   logic [7:0] ptr_q       = `PTR_RESET;
   logic       rw_q        = 1'b0;
   logic       sda_drv_q   = 1'b0;        // drive low on falling-edge update
   logic       wr_tgl_q    = 1'b0;
   logic       rd_tgl_q    = 1'b0;
   logic [7:0] wr_addr_q   = 8'h00;
   logic [7:0] wr_data_q   = 8'h00;
   logic [7:0] rd_addr_q   = 8'h00;
   logic [1:0] strap_q;
   logic       start_tgl_q = 1'b0;        // start seen (sda falling)
   logic       stop_tgl_q  = 1'b0;        // stop seen (sda rising)
   logic       start_ack_q = 1'b0;
   logic       stop_ack_q  = 1'b0;
   logic       tmo_tgl_sync;
   logic       tmo_ack_q   = 1'b0;

   wire [6:0] own_addr   = {`ADDR_FIXED_HI, strap_q};
   wire [7:0] byte_in    = {shift_q[6:0], sda_in};
   wire       start_new  = start_tgl_q != start_ack_q;
   wire       stop_new   = stop_tgl_q != stop_ack_q;
   wire       tmo_new    = tmo_tgl_sync != tmo_ack_q;
   wire       addr_match = byte_in[7:1] == own_addr;

   // start/stop detection: sda edges while scl is high
   always_ff @(negedge sda_in) begin
      if (scl_in) begin
         start_tgl_q <= ~start_tgl_q;
      end
   end
   always_ff @(posedge sda_in) begin
      if (scl_in) begin
         stop_tgl_q <= ~stop_tgl_q;
      end
   end
   // strap decode, sampled in system domain below
   logic [1:0] strap_sys_q;
   always_comb begin
      strap_q = strap_sys_q;
   end

   // sample on rising scl: one bit per pulse
   always_ff @(posedge scl_in) begin
      start_ack_q <= start_tgl_q;
      stop_ack_q  <= stop_tgl_q;
      tmo_ack_q   <= tmo_tgl_sync;
      if (start_new) begin
         state_q <= i2c_port_pkg::ST_ADDR;
         bit_q   <= 3'd6;
         shift_q <= {7'h00, sda_in};
      end else if (stop_new || tmo_new) begin
         state_q <= i2c_port_pkg::ST_IDLE;
      end else begin
         case (state_q)
            i2c_port_pkg::ST_ADDR, i2c_port_pkg::ST_RX: begin
               shift_q <= byte_in;
               bit_q   <= bit_q - 3'd1;
               if (bit_q == 3'd0) begin
                  if (state_q == i2c_port_pkg::ST_ADDR) begin
                     rw_q        <= sda_in;
                     ptr_phase_q <= ~sda_in;
                     state_q     <= addr_match ? i2c_port_pkg::ST_AACK
                                               : i2c_port_pkg::ST_IDLE;
                  end else begin
                     if (ptr_phase_q) begin
                        ptr_q <= byte_in;
                     end else begin
                        wr_addr_q <= ptr_q;
                        wr_data_q <= byte_in;
                        wr_tgl_q  <= ~wr_tgl_q;
                        ptr_q     <= ptr_q + 8'h01;
                     end
                     ptr_phase_q <= 1'b0;
                     state_q     <= i2c_port_pkg::ST_AACK;
                  end
               end
            end
            i2c_port_pkg::ST_AACK: begin
               bit_q   <= 3'd7;
               shift_q <= rd_data_in;
               state_q <= rw_q ? i2c_port_pkg::ST_TX : i2c_port_pkg::ST_RX;
               if (rw_q) begin
                  rd_addr_q <= ptr_q;
                  rd_tgl_q  <= ~rd_tgl_q;
                  ptr_q     <= ptr_q + 8'h01;
               end
            end
            i2c_port_pkg::ST_TX: begin
               shift_q <= {shift_q[6:0], 1'b1};
               bit_q   <= bit_q - 3'd1;
               if (bit_q == 3'd0) begin
                  state_q <= i2c_port_pkg::ST_MACK;
               end
            end
            i2c_port_pkg::ST_MACK: begin
               // master nack ends transmission
               if (sda_in) begin
                  state_q <= i2c_port_pkg::ST_IDLE;
               end else begin
                  bit_q     <= 3'd7;
                  shift_q   <= rd_data_in;
                  state_q   <= i2c_port_pkg::ST_TX;
                  rd_addr_q <= ptr_q;
                  rd_tgl_q  <= ~rd_tgl_q;
                  ptr_q     <= ptr_q + 8'h01;
               end
            end
            default: state_q <= i2c_port_pkg::ST_IDLE;
         endcase
      end
   end

   // drive sda on falling scl, stable through high phase
   always_ff @(negedge scl_in) begin
      case (state_q)
         i2c_port_pkg::ST_AACK: sda_drv_q <= 1'b1;
         i2c_port_pkg::ST_TX:   sda_drv_q <= ~shift_q[7];
         default:               sda_drv_q <= 1'b0;
      endcase
   end

   // open drain: only pull low, never drive scl
   // a stop needs no further scl edge to end the transfer
   wire busy_link = (state_q != i2c_port_pkg::ST_IDLE && !stop_new) || start_new;
   always_comb begin
      sda_out    = 1'b0;
      sda_oe_out = sda_drv_q && busy_link && !srst_in;
   end

   // ========================================================
   // system domain: synchronisers, strap, timeout, core strobes
   logic [7:0] sync_q;
   sync2 #(.WIDTH(8)) u_sync (
      .clk_in  (clk_in),
      .srst_in (srst_in),
      .d_in    ({scl_in, sda_in, wr_tgl_q, rd_tgl_q, busy_link,
                 strap_sda_in, strap_hi_in, strap_lo_in}),
      .q_out   (sync_q)
   );
   wire scl_s       = sync_q[7];
   wire sda_s       = sync_q[6];
   wire wr_s        = sync_q[5];
   wire rd_s        = sync_q[4];
   wire busy_s      = sync_q[3];
   wire strap_sda_s = sync_q[2];
   wire strap_hi_s  = sync_q[1];
   wire strap_lo_s  = sync_q[0];

   logic        wr_seen_q;
   logic        rd_seen_q;
   logic        tmo_tgl_q;
   logic        scl_prev_q;
   logic [31:0] tmo_cnt_q;

   // strap decode: short to sda wins, then level
   wire [1:0] strap_d = strap_sda_s ? `STRAP_SDA :
                        strap_hi_s  ? `STRAP_VDD :
                        strap_lo_s  ? `STRAP_GND : `STRAP_SCL;
   wire line_low = !scl_s || !sda_s;
   wire tmo_on   = !timeout_dis_in;
   wire tmo_hit  = tmo_cnt_q == 32'(TIMEOUT_CYCLES - 1);

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         wr_seen_q    <= 1'b0;
         rd_seen_q    <= 1'b0;
         tmo_tgl_q    <= 1'b0;
         tmo_cnt_q    <= 32'h0;
         scl_prev_q   <= 1'b1;
         strap_sys_q  <= `STRAP_GND;
         req_out      <= '0;
         ptr_out      <= 8'h00;
      end else begin
         wr_seen_q      <= wr_s;
         rd_seen_q      <= rd_s;
         req_out.wr     <= wr_s != wr_seen_q;
         req_out.rd     <= rd_s != rd_seen_q;
         req_out.addr   <= (rd_s != rd_seen_q) ? rd_addr_q : wr_addr_q;
         req_out.data   <= wr_data_q;
         scl_prev_q     <= scl_s;
         // pointer only moves on scl rise: copy it once that rise is synced
         if (scl_s && !scl_prev_q) begin
            ptr_out <= ptr_q;
         end
         // strap follows the synced pins only while the link is idle
         if (!busy_s) begin
            strap_sys_q <= strap_d;
         end
         // count while a line is low inside a transfer
         if (tmo_on && busy_s && line_low) begin
            tmo_cnt_q <= tmo_hit ? 32'h0 : tmo_cnt_q + 32'h1;
            if (tmo_hit) begin
               tmo_tgl_q <= ~tmo_tgl_q;
            end
         end else begin
            tmo_cnt_q <= 32'h0;
         end
      end
   end
   always_comb begin
      tmo_tgl_sync = tmo_tgl_q;
      busy_out     = busy_s;
   end
endmodule // gpio_expander_i2c_slave_port

// ### testbench/i2c_port_sva.sv
`timescale 1ns/10ps
// ==========
// pin checker for the slave port
module i2c_port_sva #(
   parameter int TIMEOUT_CYCLES = 200
) (
   // clock, reset and link pins
   input wire logic                      clk_in,
   input wire logic                      srst_in,
   input wire logic                      scl_in,
   input wire logic                      sda_in,
   input wire logic                      sda_out,
   input wire logic                      sda_oe_out,
   // strap and config
   input wire logic                      strap_lo_in,
   input wire logic                      strap_hi_in,
   input wire logic                      strap_sda_in,
   input wire logic                      timeout_dis_in,
   // core side
   input wire i2c_port_pkg::reg_req_type req_out,
   input wire logic [7:0]                rd_data_in,
   input wire logic [7:0]                ptr_out,
   input wire logic                      busy_out
);
   logic [7:0] wr_addr_q;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   // remember the address of the last write pulse
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         wr_addr_q <= 8'h00;
      end else if (req_out.wr) begin
         wr_addr_q <= req_out.addr;
      end
   end
   // sda edges while scl stays high
   sequence start_seq;
      scl_in && $past(scl_in) && $fell(sda_in);
   endsequence
   sequence stop_seq;
      scl_in && $past(scl_in) && $rose(sda_in);
   endsequence
   sda_low_only_a: assert property (sda_out == 1'b0)
      else $error("sda driven high");
   oe_change_low_a: assert property ($changed(sda_oe_out) |-> !scl_in)
      else $error("sda drive changed while scl high");
   idle_release_a: assert property (!busy_out |-> !sda_oe_out)
      else $error("sda pulled while idle");
   start_busy_a: assert property (start_seq |-> ##[1:8] busy_out)
      else $error("start not seen");
   stop_idle_a: assert property (stop_seq |-> ##[1:8] !busy_out)
      else $error("stop not seen");
   wr_pulse_a: assert property (req_out.wr |=> !req_out.wr)
      else $error("write pulse too long");
   rd_pulse_a: assert property (req_out.rd |=> !req_out.rd)
      else $error("read pulse too long");
   ptr_step_a: assert property ($past(req_out.wr) |-> ##[0:20] ptr_out == wr_addr_q + 8'h01)
      else $error("pointer did not advance");
endmodule // i2c_port_sva

// ### testbench/i2c_master_model.sv
`timescale 1ns/10ps
// ==========
// bus master: makes every scl pulse, drives sda open drain
module i2c_master_model (
   // link pins
   output logic      scl_out,
   output logic      sda_drv_out,
   input  wire logic sda_in
);
   localparam realtime Q = 3.75;
   // both lines released while idle
   initial begin
      scl_out = 1'b1;
      sda_drv_out = 1'b1;
   end
   // start, or repeated start from scl low
   task automatic start;
      #Q sda_drv_out = 1'b1;
      #Q scl_out = 1'b1;
      #(2*Q) sda_drv_out = 1'b0;
      #(2*Q) scl_out = 1'b0;
   endtask
   // stop, lines left released
   task automatic stop;
      #Q sda_drv_out = 1'b0;
      #Q scl_out = 1'b1;
      #(2*Q) sda_drv_out = 1'b1;
      #(2*Q);
   endtask
   // one scl pulse, sda set while scl low, sampled mid high
   task automatic pulse(input logic d, output logic s);
      #Q sda_drv_out = d;
      #Q scl_out = 1'b1;
      #Q s = sda_in;
      #Q scl_out = 1'b0;
   endtask
   task automatic put_bits(input logic [7:0] v, input int n);
      logic s;
      for (int i = 0; i < n; i++) begin
         pulse(v[7-i], s);
      end
   endtask
   // byte out, ninth pulse released for the slave
   task automatic wr_byte(input logic [7:0] v, output logic ack);
      logic s;
      put_bits(v, 8);
      pulse(1'b1, s);
      ack = ~s;
   endtask
   // byte in, master answers the ninth pulse
   task automatic rd_byte(output logic [7:0] v, input logic m_ack);
      logic b;
      for (int i = 0; i < 8; i++) begin
         pulse(1'b1, b);
         v[7-i] = b;
      end
      pulse(~m_ack, b);
   endtask
endmodule // i2c_master_model

// ### testbench/testbench.sv
`timescale 1ns/10ps
`include "i2c_port_consts.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
   // ==========
   // pins and bench state
   localparam int TO_CYC = 200;
   logic       clk_in = 1'b0;
   logic       srst_in = 1'b1;
   logic       strap_lo_in = 1'b0;
   logic       strap_hi_in = 1'b0;
   logic       strap_sda_in = 1'b0;
   logic       timeout_dis_in = 1'b1;
   logic       scl, sda_drv, sda_out, sda_oe_out, busy_out, a;
   logic [7:0] ptr_out, rd_data_in, p, d0, d1, v;
   logic [6:0] own;
   wire logic  sda;
   logic [15:0] wrq [$];
   int         n_mismatch = 0;
   int         total_checks = 0;
   int         seed = 32'h5accea88;
   i2c_port_pkg::reg_req_type req_out;
   function automatic logic [7:0] pat(input logic [7:0] x);
      return {x[3:0], x[7:4]} ^ 8'h3c;
   endfunction
   // clock, pulled-up sda wire and register read data
   always #2 clk_in = ~clk_in;
   assign sda = sda_drv & (sda_oe_out ? sda_out : 1'b1);
   assign rd_data_in = pat(ptr_out);
   gpio_expander_i2c_slave_port #(.TIMEOUT_CYCLES(TO_CYC)) uut (.clk_in(clk_in),
      .srst_in(srst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_out(sda_oe_out), .strap_lo_in(strap_lo_in), .strap_hi_in(strap_hi_in),
      .strap_sda_in(strap_sda_in), .timeout_dis_in(timeout_dis_in), .req_out(req_out),
      .rd_data_in(rd_data_in), .ptr_out(ptr_out), .busy_out(busy_out));
   i2c_master_model mst (.scl_out(scl), .sda_drv_out(sda_drv), .sda_in(sda));
   // log write requests toward the core
   always @(posedge clk_in) begin
      if (req_out.wr === 1'b1) begin
         wrq.push_back({req_out.addr, req_out.data});
      end
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk_wr(input logic [7:0] ad, input logic [7:0] dt);
      logic [15:0] got;
      got = (wrq.size() > 0) ? wrq.pop_front() : 16'hxxxx;
      `CHK("write_req", {ad, dt}, got)
   endtask
   task automatic reset_strap(input logic [1:0] c);
      @(negedge clk_in);
      strap_lo_in = (c == `STRAP_GND);
      strap_hi_in = (c == `STRAP_VDD);
      strap_sda_in = (c == `STRAP_SDA);
      srst_in = 1'b1;
      repeat (16) @(negedge clk_in);
      srst_in = 1'b0;
      repeat (4) @(negedge clk_in);
      own = {`ADDR_FIXED_HI, c};
   endtask
   // start, own address for write, pointer byte
   task automatic set_ptr(input logic [7:0] pp);
      mst.start;
      mst.wr_byte({own, 1'b0}, a);
      `CHK("addr_ack", 1'b1, a)
      mst.wr_byte(pp, a);
      `CHK("ptr_ack", 1'b1, a)
   endtask
   // ==========
   // main sequence
   initial begin
      for (int c = 0; c < 4; c++) begin
         reset_strap(c[1:0]);
         p = $random(seed);
         d0 = $random(seed);
         d1 = $random(seed);
         set_ptr(p);
         mst.wr_byte(d0, a);
         `CHK("data_ack", 1'b1, a)
         mst.wr_byte(d1, a);
         mst.stop;
         chk_wr(p, d0);
         chk_wr(p + 8'h01, d1);
         `CHK("ptr_after_wr", p + 8'h02, ptr_out)
         for (int k = 0; k < 2; k++) begin
            mst.start;
            mst.wr_byte({own ^ (k ? 7'h40 : 7'h01), 1'b0}, a);
            `CHK("foreign_ack", 1'b0, a)
            mst.wr_byte(d0, a);
            `CHK("ignored_ack", 1'b0, a)
            mst.stop;
         end
         `CHK("foreign_wr", 0, wrq.size())
         $display("test strap %0d finished", c);
      end
      p = 8'hff;
      set_ptr(p);
      mst.stop;
      repeat (8) @(negedge clk_in);
      `CHK("ptr_only", p, ptr_out)
      `CHK("ptr_only_wr", 0, wrq.size())
      set_ptr(p);
      mst.start;
      mst.wr_byte({own, 1'b1}, a);
      `CHK("read_ack", 1'b1, a)
      for (int i = 0; i < 3; i++) begin
         mst.rd_byte(v, i < 2);
         `CHK("read_data", pat(p + i[7:0]), v)
      end
      mst.stop;
      `CHK("bus_idle", 1'b1, sda)
      $display("test read finished");
      for (int td = 0; td < 2; td++) begin
         @(negedge clk_in);
         timeout_dis_in = td[0];
         p = $random(seed);
         mst.start;
         mst.wr_byte({own, 1'b0}, a);
         mst.put_bits(p, 4);
         repeat (TO_CYC + 100) @(negedge clk_in);
         mst.put_bits(p << 4, 4);
         mst.pulse(1'b1, a);
         `CHK("stall_ack", td[0], ~a)
         mst.stop;
      end
      `CHK("stall_wr", 0, wrq.size())
      $display("test timeout finished");
      summarize;
   end
   // hang guard
   initial begin
      #100000;
      n_mismatch++;
      $display("[ERR] run_time expected end seen timeout");
      summarize;
   end
endmodule // testbench
bind gpio_expander_i2c_slave_port i2c_port_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
   .clk_in(clk_in), .srst_in(srst_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_out(sda_oe_out), .strap_lo_in(strap_lo_in), .strap_hi_in(strap_hi_in),
   .strap_sda_in(strap_sda_in), .timeout_dis_in(timeout_dis_in), .req_out(req_out),
   .rd_data_in(rd_data_in), .ptr_out(ptr_out), .busy_out(busy_out));
